//--- rtl/ifeb_top.sv
// Interrupt flag status registers 1 to 4 and enable register 0
`timescale 1ns/10ps
`include "ifeb_defs.svh"
module ifeb_top
  import ifeb_pkg::*;
#(
  parameter bit CAN_PRESENT = 1'b1
)(
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  input  wire logic          wb_cyc_in,
  input  wire logic          wb_stb_in,
  input  wire logic          wb_we_in,
  input  wire logic [7:0]    wb_adr_in,
  input  wire logic [3:0]    wb_sel_in,
  input  wire logic [31:0]   wb_dat_in,
  output logic      [31:0]   wb_dat_out,
  output logic               wb_ack_out,
  input  wire ifeb_word_type flag_ev1_in,
  input  wire ifeb_word_type flag_ev2_in,
  input  wire ifeb_word_type flag_ev3_in,
  input  wire ifeb_word_type flag_ev4_in,
  input  wire ifeb_word_type flag0_in,
  input  wire ifeb_word_type en1_in,
  input  wire ifeb_word_type en2_in,
  input  wire ifeb_word_type en3_in,
  input  wire ifeb_word_type en4_in,
  output ifeb_word_type      flag1_out,
  output ifeb_word_type      flag2_out,
  output ifeb_word_type      flag3_out,
  output ifeb_word_type      flag4_out,
  output ifeb_word_type      enable0_out,
  output ifeb_word_type      req0_out,
  output ifeb_word_type      req1_out,
  output ifeb_word_type      req2_out,
  output ifeb_word_type      req3_out,
  output ifeb_word_type      req4_out,
  output logic               irq_out
);
  // CAN sources drop out of the implemented set when absent
  localparam logic [15:0] IMPL1 = `IFEB_IMPL_FLAG1;
  localparam logic [15:0] IMPL2 = CAN_PRESENT ? `IFEB_IMPL_FLAG2
                                              : (`IFEB_IMPL_FLAG2 & ~`IFEB_CAN_MASK2);
  localparam logic [15:0] IMPL3 = `IFEB_IMPL_FLAG3;
  localparam logic [15:0] IMPL4 = CAN_PRESENT ? `IFEB_IMPL_FLAG4
                                              : (`IFEB_IMPL_FLAG4 & ~`IFEB_CAN_MASK4);
  localparam logic [15:0] IMPLE = `IFEB_IMPL_EN0;

  ifeb_reg_if    rb ();
  ifeb_word_type flag1_w;
  ifeb_word_type flag2_w;
  ifeb_word_type flag3_w;
  ifeb_word_type flag4_w;
  ifeb_word_type new1_w;
  ifeb_word_type new2_w;
  ifeb_word_type new3_w;
  ifeb_word_type new4_w;
  ifeb_word_type en0_r;
  ifeb_word_type en0_nxt;
  ifeb_word_type lane;
  logic [3:0]    evst_r;
  logic [3:0]    evst_nxt;
  logic [3:0]    evmask_r;
  logic [3:0]    ev_hit;
  logic          wr1;
  logic          wr2;
  logic          wr3;
  logic          wr4;

  ifeb_wb_slave u_bus (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .wb_cyc_in  (wb_cyc_in),
    .wb_stb_in  (wb_stb_in),
    .wb_we_in   (wb_we_in),
    .wb_adr_in  (wb_adr_in),
    .wb_sel_in  (wb_sel_in),
    .wb_dat_in  (wb_dat_in),
    .wb_dat_out (wb_dat_out),
    .wb_ack_out (wb_ack_out),
    .rb         (rb)
  );

  assign wr1 = rb.wr && (rb.sel == IFEB_SEL_FLAG1);
  assign wr2 = rb.wr && (rb.sel == IFEB_SEL_FLAG2);
  assign wr3 = rb.wr && (rb.sel == IFEB_SEL_FLAG3);
  assign wr4 = rb.wr && (rb.sel == IFEB_SEL_FLAG4);

  // Comparator and I2C1 flags
  ifeb_flag_reg #(.IMPL(IMPL1)) u_flag1 (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .wr_in     (wr1),
    .be_in     (rb.be),
    .wdata_in  (rb.wdata),
    .set_in    (flag_ev1_in),
    .flags_out (flag1_w),
    .new_out   (new1_w)
  );

  // DMA4, parallel port, DMA3, CAN, SPI2
  ifeb_flag_reg #(.IMPL(IMPL2)) u_flag2 (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .wr_in     (wr2),
    .be_in     (rb.be),
    .wdata_in  (rb.wdata),
    .set_in    (flag_ev2_in),
    .flags_out (flag2_w),
    .new_out   (new2_w)
  );

  // Calendar clock and DMA5
  ifeb_flag_reg #(.IMPL(IMPL3)) u_flag3 (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .wr_in     (wr3),
    .be_in     (rb.be),
    .wdata_in  (rb.wdata),
    .set_in    (flag_ev3_in),
    .flags_out (flag3_w),
    .new_out   (new3_w)
  );

  // CAN transmit, DMA7, DMA6, checksum, UART errors
  ifeb_flag_reg #(.IMPL(IMPL4)) u_flag4 (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .wr_in     (wr4),
    .be_in     (rb.be),
    .wdata_in  (rb.wdata),
    .set_in    (flag_ev4_in),
    .flags_out (flag4_w),
    .new_out   (new4_w)
  );

  // Enable register 0
  always_comb
  begin
    lane    = {{8{rb.be[1]}}, {8{rb.be[0]}}};
    en0_nxt = en0_r;
    if (rb.wr && (rb.sel == IFEB_SEL_EN0))
      en0_nxt = ((rb.wdata & lane) | (en0_r & ~lane)) & IMPLE;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      en0_r <= `IFEB_RST_WORD;
    else
      en0_r <= en0_nxt;
  end

  // Forward only flagged and enabled sources
  assign req0_out = flag0_in & en0_r;
  assign req1_out = flag1_w & en1_in;
  assign req2_out = flag2_w & en2_in;
  assign req3_out = flag3_w & en3_in;
  assign req4_out = flag4_w & en4_in;

  assign flag1_out   = flag1_w;
  assign flag2_out   = flag2_w;
  assign flag3_out   = flag3_w;
  assign flag4_out   = flag4_w;
  assign enable0_out = en0_r;

  // Block event status: one bit per flag register
  assign ev_hit = {|new4_w, |new3_w, |new2_w, |new1_w};

  always_comb
  begin
    evst_nxt = evst_r;
    if (rb.wr && (rb.sel == IFEB_SEL_EVST) && rb.be[0])
      evst_nxt = evst_r & ~rb.wdata[3:0];
    evst_nxt = evst_nxt | ev_hit;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      evst_r <= `IFEB_RST_EV;
    else
      evst_r <= evst_nxt;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      evmask_r <= `IFEB_RST_EV;
    else if (rb.wr && (rb.sel == IFEB_SEL_EVMASK) && rb.be[0])
      evmask_r <= rb.wdata[3:0];
  end

  assign irq_out = |(evst_r & evmask_r);

  // Read mux
  always_comb
  begin
    case (rb.sel)
      IFEB_SEL_FLAG1:  rb.rdata = flag1_w;
      IFEB_SEL_FLAG2:  rb.rdata = flag2_w;
      IFEB_SEL_FLAG3:  rb.rdata = flag3_w;
      IFEB_SEL_FLAG4:  rb.rdata = flag4_w;
      IFEB_SEL_EN0:    rb.rdata = en0_r;
      IFEB_SEL_EVST:   rb.rdata = {12'h000, evst_r};
      IFEB_SEL_EVMASK: rb.rdata = {12'h000, evmask_r};
      default:         rb.rdata = `IFEB_RST_WORD;
    endcase
  end

  // Checks
  ifeb_word_type ev1_m;
  ifeb_word_type ev2_m;
  ifeb_word_type ev3_m;
  ifeb_word_type ev4_m;
  logic          clr1_lo;

  assign ev1_m   = flag_ev1_in & IMPL1;
  assign ev2_m   = flag_ev2_in & IMPL2;
  assign ev3_m   = flag_ev3_in & IMPL3;
  assign ev4_m   = flag_ev4_in & IMPL4;
  assign clr1_lo = wr1 && rb.be[0] && (rb.wdata[2:0] == 3'h0);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_flag_hold_set: assert property (
    !wr1 |=> flag1_w == ($past(flag1_w) | $past(ev1_m)))
    else $error("flag register 1 lost or gained a bit without cause");

  a_reset_all_zero: assert property (
    @(posedge clk_in) $rose(nrst_in) |-> (flag1_w == 16'h0000) && (flag2_w == 16'h0000)
      && (flag3_w == 16'h0000) && (flag4_w == 16'h0000) && (en0_r == 16'h0000))
    else $error("flags or enables not zero after reset");

  a_read_upper_zero: assert property (
    wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
    else $error("upper read data not zero");

  a_unimpl_bits_zero: assert property (
    ((flag1_w & ~IMPL1) == 16'h0000) && ((flag2_w & ~IMPL2) == 16'h0000)
      && ((flag3_w & ~IMPL3) == 16'h0000) && ((flag4_w & ~IMPL4) == 16'h0000))
    else $error("unimplemented flag bit set");

  a_comparator_write: assert property (
    (wr1 && rb.be[0] && rb.wdata[`IFEB_POS_COMPARATOR]) |=> flag1_w[`IFEB_POS_COMPARATOR] ##1
      (flag1_w[`IFEB_POS_COMPARATOR] || wr1))
    else $error("comparator flag write not kept");

  a_flag2_layout: assert property (
    flag_ev2_in[14] && flag_ev2_in[0] |=> flag2_w[14] && flag2_w[0] && (flag2_w[12:5] == 8'h00))
    else $error("flag register 2 layout wrong");

  a_flag3_layout: assert property (
    flag_ev3_in[13] |=> flag3_w[13] && !flag3_w[15] && (flag3_w[12:0] == 13'h0000))
    else $error("flag register 3 layout wrong");

  a_flag4_layout: assert property (
    flag_ev4_in[1] |=> flag4_w[1] && !flag4_w[0] && (flag4_w[15:7] == 9'h000))
    else $error("flag register 4 layout wrong");

  a_can_gated_off: assert property (
    !CAN_PRESENT |-> !flag2_w[`IFEB_POS_CAN_EVENT] && !flag2_w[`IFEB_POS_CAN_RECEIVE]
      && !flag4_w[`IFEB_POS_CAN_TRANSMIT] && !req2_out[`IFEB_POS_CAN_EVENT])
    else $error("absent CAN source took effect");

  a_enable_blocks: assert property (
    (rb.wr && (rb.sel == IFEB_SEL_EN0) && (rb.be == 2'b11) && (rb.wdata == 16'h0000))
      |=> (req0_out == 16'h0000) [*2] or (rb.wr [*1]))
    else $error("cleared enable did not block requests");

  a_en0_top_zero: assert property (
    (rb.wr && (rb.sel == IFEB_SEL_EN0) && rb.be[1]) |=> !en0_r[15] && (en0_r[14] == $past(rb.wdata[14])))
    else $error("enable register 0 bit 15 or 14 wrong");

  a_req_needs_both: assert property (
    (|req2_out) |-> (|(flag2_w & en2_in)) && ((req2_out & ~flag2_w) == 16'h0000))
    else $error("request forwarded without flag");

  a_set_beats_clear: assert property (
    (clr1_lo && (ev1_m[2:0] != 3'h0)) |=> (flag1_w[2:0] == $past(ev1_m[2:0])))
    else $error("event lost under a clearing write");

  a_clear_by_zero: assert property (
    (clr1_lo && (ev1_m[2:0] == 3'h0)) |=> flag1_w[2:0] == 3'h0)
    else $error("writing zero did not clear flags");

  a_irq_follows: assert property (
    ((|new1_w) && evmask_r[0] && !(rb.wr && (rb.sel == IFEB_SEL_EVMASK))) |=> irq_out)
    else $error("masked-in event raised no interrupt");

  a_ack_single: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");

  a_flag2_hold_set: assert property (
    !wr2 |=> flag2_w == ($past(flag2_w) | $past(ev2_m)))
    else $error("flag register 2 lost or gained a bit without cause");

  a_flag3_hold_set: assert property (
    !wr3 |=> flag3_w == ($past(flag3_w) | $past(ev3_m)))
    else $error("flag register 3 lost or gained a bit without cause");

  a_flag4_hold_set: assert property (
    !wr4 |=> flag4_w == ($past(flag4_w) | $past(ev4_m)))
    else $error("flag register 4 lost or gained a bit without cause");

  a_flag1_write_lands: assert property (
    (wr1 && (rb.be == 2'b11)) |=> flag1_w == (($past(rb.wdata) | $past(ev1_m)) & IMPL1))
    else $error("full write to flag register 1 not taken");

  a_en0_hold: assert property (
    !(rb.wr && (rb.sel == IFEB_SEL_EN0)) |=> $stable(en0_r))
    else $error("enable register 0 changed without a write");

  a_en0_bit15_zero: assert property (
    !en0_r[15])
    else $error("enable register 0 bit 15 set");

  a_ack_after_req: assert property (
    (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
    else $error("request not answered in one cycle");

  a_no_ack_idle: assert property (
    !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without a request");

  a_unmapped_read_zero: assert property (
    (wb_ack_out && !wb_we_in && (rb.sel == IFEB_SEL_NONE)) |-> (wb_dat_out == 32'h00000000))
    else $error("unmapped read not zero");

  a_evst_set: assert property (
    (|new2_w) |=> evst_r[1])
    else $error("event on flag register 2 not recorded");

  a_evst_hold: assert property (
    (!(rb.wr && (rb.sel == IFEB_SEL_EVST)) && (ev_hit == 4'h0)) |=> $stable(evst_r))
    else $error("event status changed without cause");

  a_evst_clear: assert property (
    (rb.wr && (rb.sel == IFEB_SEL_EVST) && rb.be[0] && (rb.wdata[3:0] == 4'hf) && (ev_hit == 4'h0))
      |=> (evst_r == 4'h0))
    else $error("event status not cleared by ones");

  c_set_and_clear: cover property (clr1_lo && (ev1_m[2:0] != 3'h0));
  c_irq_rise:      cover property ($rose(irq_out));
  c_read_flag2:    cover property (wb_ack_out && !wb_we_in && (rb.sel == IFEB_SEL_FLAG2) ##1 1'b1);
  c_req_forward:   cover property ($rose(|req0_out));
  c_flag4_event:   cover property (|new4_w);
endmodule // ifeb_top

//--- rtl/ifeb_defs.svh
// Offsets, field positions, implemented-bit masks and reset values
// How it works
// - A flag bit reads 1 after its source raised a request and 0 otherwise, and software may read and write it.
// - Every implemented flag and enable bit is 0 after power-on reset.
// - Unimplemented bit positions read 0 and ignore writes.
// - Flag register 1 holds the comparator flag at bit 2, the I2C1 master flag at bit 1, the I2C1 slave flag at bit 0.
// - Flag register 2 holds DMA4 and parallel port at bits 14-13, DMA3, CAN event, CAN receive, SPI2 event, SPI2 error at bits 4-0.
// - Flag register 3 holds the calendar clock flag at bit 14 and the DMA5 flag at bit 13, all else unimplemented.
// - Flag register 4 holds CAN transmit, DMA7, DMA6, checksum, UART2 error, UART1 error at bits 6-1, all else unimplemented.
// - Without the CAN controller the CAN event, receive and transmit sources are disabled and never take effect.
// - An enable bit at 1 lets its source's request through and at 0 blocks it.
// - Enable register 0 holds fifteen enables at bits 14-0, from DMA1 done down to external input 0, bit 15 unimplemented.
`ifndef IFEB_DEFS_SVH
`define IFEB_DEFS_SVH

`define IFEB_OFS_FLAG1        8'h00
`define IFEB_OFS_FLAG2        8'h04
`define IFEB_OFS_FLAG3        8'h08
`define IFEB_OFS_FLAG4        8'h0c
`define IFEB_OFS_EN0          8'h10
`define IFEB_OFS_EVST         8'h14
`define IFEB_OFS_EVMASK       8'h18

`define IFEB_POS_COMPARATOR   2
`define IFEB_POS_I2C1_MASTER  1
`define IFEB_POS_I2C1_SLAVE   0
`define IFEB_POS_CAN_EVENT    3
`define IFEB_POS_CAN_RECEIVE  2
`define IFEB_POS_CAN_TRANSMIT 6

`define IFEB_IMPL_FLAG1       16'h0007
`define IFEB_IMPL_FLAG2       16'h601f
`define IFEB_IMPL_FLAG3       16'h6000
`define IFEB_IMPL_FLAG4       16'h007e
`define IFEB_IMPL_EN0         16'h7fff
`define IFEB_CAN_MASK2        16'h000c
`define IFEB_CAN_MASK4        16'h0040

`define IFEB_RST_WORD         16'h0000
`define IFEB_RST_EV           4'h0
`define IFEB_RST_BUS          32'h00000000

`endif

//--- rtl/ifeb_pkg.sv
// Types shared by the flag and enable bank
package ifeb_pkg;
  typedef logic [15:0] ifeb_word_type;
  typedef enum logic [2:0] {
    IFEB_SEL_FLAG1  = 3'b000,
    IFEB_SEL_FLAG2  = 3'b001,
    IFEB_SEL_FLAG3  = 3'b010,
    IFEB_SEL_FLAG4  = 3'b011,
    IFEB_SEL_EN0    = 3'b100,
    IFEB_SEL_EVST   = 3'b101,
    IFEB_SEL_EVMASK = 3'b110,
    IFEB_SEL_NONE   = 3'b111
  } ifeb_sel_type;
endpackage

//--- rtl/ifeb_reg_if.sv
// Register access channel between bus slave and core
`timescale 1ns/10ps
interface ifeb_reg_if
  import ifeb_pkg::*;
  ();
  logic          wr;
  ifeb_sel_type  sel;
  logic [1:0]    be;
  ifeb_word_type wdata;
  ifeb_word_type rdata;
  modport bus  (output wr, sel, be, wdata, input rdata);
  modport core (input wr, sel, be, wdata, output rdata);
endinterface // ifeb_reg_if

//--- rtl/ifeb_flag_reg.sv
// One 16-bit sticky flag register
`timescale 1ns/10ps
`include "ifeb_defs.svh"
module ifeb_flag_reg
  import ifeb_pkg::*;
#(
  parameter logic [15:0] IMPL = 16'h0000
)(
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  input  wire logic          wr_in,
  input  wire logic [1:0]    be_in,
  input  wire ifeb_word_type wdata_in,
  input  wire ifeb_word_type set_in,
  output ifeb_word_type      flags_out,
  output ifeb_word_type      new_out
);
  ifeb_word_type flags_r;
  ifeb_word_type flags_nxt;
  ifeb_word_type lane;

  always_comb
  begin
    lane      = {{8{be_in[1]}}, {8{be_in[0]}}};
    flags_nxt = wr_in ? ((wdata_in & lane) | (flags_r & ~lane)) : flags_r;
    flags_nxt = (flags_nxt | set_in) & IMPL;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      flags_r <= `IFEB_RST_WORD;
    else
      flags_r <= flags_nxt;
  end

  assign flags_out = flags_r;
  assign new_out   = set_in & ~flags_r & IMPL;
endmodule // ifeb_flag_reg

//--- rtl/ifeb_wb_slave.sv
// Classic Wishbone slave front end
`timescale 1ns/10ps
`include "ifeb_defs.svh"
module ifeb_wb_slave
  import ifeb_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  ifeb_reg_if.bus          rb
);
  logic        ack_r;
  logic [31:0] dat_r;
  logic        req;

  assign req = wb_cyc_in & wb_stb_in;

  always_comb
  begin
    case (wb_adr_in)
      `IFEB_OFS_FLAG1:  rb.sel = IFEB_SEL_FLAG1;
      `IFEB_OFS_FLAG2:  rb.sel = IFEB_SEL_FLAG2;
      `IFEB_OFS_FLAG3:  rb.sel = IFEB_SEL_FLAG3;
      `IFEB_OFS_FLAG4:  rb.sel = IFEB_SEL_FLAG4;
      `IFEB_OFS_EN0:    rb.sel = IFEB_SEL_EN0;
      `IFEB_OFS_EVST:   rb.sel = IFEB_SEL_EVST;
      `IFEB_OFS_EVMASK: rb.sel = IFEB_SEL_EVMASK;
      default:          rb.sel = IFEB_SEL_NONE;
    endcase
  end

  // Write lands on the edge where ack is seen
  assign rb.wr    = req & wb_we_in & ack_r;
  assign rb.be    = wb_sel_in[1:0];
  assign rb.wdata = wb_dat_in[15:0];

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      dat_r <= `IFEB_RST_BUS;
    else if (req && !ack_r)
      dat_r <= {16'h0000, rb.rdata};
  end

  assign wb_dat_out = dat_r;
  assign wb_ack_out = ack_r;
endmodule // ifeb_wb_slave

//--- sim/ifeb_periph_model.sv
// Peripheral side: raises flag event pulses on command
`timescale 1ns/10ps
module ifeb_periph_model
  import ifeb_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  input  wire logic          go_in,
  input  wire logic [1:0]    reg_in,
  input  wire ifeb_word_type bits_in,
  output ifeb_word_type      ev1_out,
  output ifeb_word_type      ev2_out,
  output ifeb_word_type      ev3_out,
  output ifeb_word_type      ev4_out
);
  // One event cycle per go cycle; held go gives a level
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ev1_out <= 16'h0000;
      ev2_out <= 16'h0000;
      ev3_out <= 16'h0000;
      ev4_out <= 16'h0000;
    end
    else
    begin
      ev1_out <= (go_in && reg_in == 2'h0) ? bits_in : 16'h0000;
      ev2_out <= (go_in && reg_in == 2'h1) ? bits_in : 16'h0000;
      ev3_out <= (go_in && reg_in == 2'h2) ? bits_in : 16'h0000;
      ev4_out <= (go_in && reg_in == 2'h3) ? bits_in : 16'h0000;
    end
  end
endmodule // ifeb_periph_model

//--- sim/interrupt_flag_enable_bank_bench.sv
// Self-checking bench for the flag and enable bank
`timescale 1ns/10ps
`include "ifeb_defs.svh"
module interrupt_flag_enable_bank_bench
  import ifeb_pkg::*;
;
  logic clk_in = 1'b0, nrst_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, evst = 4'h0, evmask = 4'h0;
  logic [31:0] wdat = 32'h0, wb_dat_out;
  logic [1:0] gk = 2'h0;
  logic wb_ack_out, irq_out;
  ifeb_word_type gb = '0, flag0 = '0, en1 = '0, en2 = '0, en3 = '0, en4 = '0, ee = '0;
  ifeb_word_type ev1, ev2, ev3, ev4, flag1_out, flag2_out, flag3_out, flag4_out, enable0_out;
  ifeb_word_type req0_out, req1_out, req2_out, req3_out, req4_out, nc_flag2, nc_flag4;
  ifeb_word_type ef [1:4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  ifeb_word_type impl [1:4] = '{`IFEB_IMPL_FLAG1, `IFEB_IMPL_FLAG2, `IFEB_IMPL_FLAG3, `IFEB_IMPL_FLAG4};
  logic [7:0] adr_tab [0:8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h02};
  int fail_count = 0, comparisons = 0, cycles = 0;
  logic [31:0] r;

  always #5 clk_in = ~clk_in;

  ifeb_periph_model peri (.clk_in(clk_in), .nrst_in(nrst_in), .go_in(go), .reg_in(gk), .bits_in(gb),
    .ev1_out(ev1), .ev2_out(ev2), .ev3_out(ev3), .ev4_out(ev4));

  ifeb_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .flag_ev1_in(ev1), .flag_ev2_in(ev2), .flag_ev3_in(ev3), .flag_ev4_in(ev4), .flag0_in(flag0),
    .en1_in(en1), .en2_in(en2), .en3_in(en3), .en4_in(en4), .flag1_out(flag1_out), .flag2_out(flag2_out),
    .flag3_out(flag3_out), .flag4_out(flag4_out), .enable0_out(enable0_out), .req0_out(req0_out),
    .req1_out(req1_out), .req2_out(req2_out), .req3_out(req3_out), .req4_out(req4_out), .irq_out(irq_out));

  // Variant without the CAN controller on the same stimulus
  ifeb_top #(.CAN_PRESENT(1'b0)) nocan (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(),
    .wb_ack_out(), .flag_ev1_in(ev1), .flag_ev2_in(ev2), .flag_ev3_in(ev3), .flag_ev4_in(ev4),
    .flag0_in(flag0), .en1_in(en1), .en2_in(en2), .en3_in(en3), .en4_in(en4), .flag1_out(),
    .flag2_out(nc_flag2), .flag3_out(), .flag4_out(nc_flag4), .enable0_out(), .req0_out(), .req1_out(),
    .req2_out(), .req3_out(), .req4_out(), .irq_out());

  task test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fail_count++;
      test_done();
    end
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  function automatic logic [15:0] exp_read(input logic [7:0] a);
    if (a[7:4] == 4'h0 && a[1:0] == 2'b00)
      return ef[a[3:2] + 1];
    case (a)
      `IFEB_OFS_EN0:    return ee;
      `IFEB_OFS_EVST:   return {12'h000, evst};
      `IFEB_OFS_EVMASK: return {12'h000, evmask};
      default:          return 16'h0000;
    endcase
  endfunction

  function automatic void apply_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
    logic [15:0] m;
    int k;
    m = {{8{s[1]}}, {8{s[0]}}};
    k = a[3:2] + 1;
    if (a[7:4] == 4'h0 && a[1:0] == 2'b00)
      ef[k] = ((ef[k] & ~m) | (d & m)) & impl[k];
    else if (a == `IFEB_OFS_EN0)
      ee = ((ee & ~m) | (d & m)) & `IFEB_IMPL_EN0;
    else if (a == `IFEB_OFS_EVST && s[0])
      evst = evst & ~d[3:0];
    else if (a == `IFEB_OFS_EVMASK && s[0])
      evmask = d[3:0];
  endfunction

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    n = 0;
    do begin @(posedge clk_in); n++; end while (wb_ack_out !== 1'b1 && n < 50);
    r = wb_dat_out;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50)
      chk("ack", 1'b0, 1'b1);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] s);
    wb(1'b1, a, d, {2'b00, s});
    apply_wr(a, d[15:0], s);
  endtask

  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
    chk("read", r, {16'h0000, exp_read(a)});
  endtask

  task fire(input int k, input ifeb_word_type b);
    @(posedge clk_in);
    go <= 1'b1; gk <= 2'(k - 1); gb <= b;
    @(posedge clk_in);
    go <= 1'b0;
    @(posedge clk_in);
    if ((b & impl[k] & ~ef[k]) != 16'h0)
      evst[k - 1] = 1'b1;
    ef[k] = ef[k] | (b & impl[k]);
  endtask

  task check_all();
    #1;
    chk("flag1", flag1_out, ef[1]);
    chk("flag2", flag2_out, ef[2]);
    chk("flag3", flag3_out, ef[3]);
    chk("flag4", flag4_out, ef[4]);
    chk("enable0", enable0_out, ee);
    chk("req0", req0_out, flag0 & ee);
    chk("req1", req1_out, ef[1] & en1);
    chk("req2", req2_out, ef[2] & en2);
    chk("req3", req3_out, ef[3] & en3);
    chk("req4", req4_out, ef[4] & en4);
    chk("irq", irq_out, |(evst & evmask));
    chk("nc_flag2", nc_flag2, ef[2] & ~`IFEB_CAN_MASK2);
    chk("nc_flag4", nc_flag4, ef[4] & ~`IFEB_CAN_MASK4);
  endtask

  initial
  begin
    void'($urandom(58));
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    check_all();
    for (int i = 0; i < 9; i++) rd(adr_tab[i]);
    // All ones, then all zeros, into the four flag registers and enable register 0
    for (int i = 0; i < 5; i++) wr(adr_tab[i], 32'hffffffff, 2'b11);
    for (int i = 0; i < 9; i++) rd(adr_tab[i]);
    check_all();
    for (int i = 0; i < 5; i++) wr(adr_tab[i], 32'h0, 2'b11);
    check_all();
    // Interrupt raised, cleared, then masked
    wr(`IFEB_OFS_EVMASK, 32'h2, 2'b11);
    fire(2, 16'h2000);
    check_all();
    wr(`IFEB_OFS_EVST, 32'hf, 2'b11);
    check_all();
    wr(`IFEB_OFS_EVMASK, 32'h0, 2'b11);
    fire(2, 16'h4000);
    check_all();
    // Event held through a clearing write
    wr(`IFEB_OFS_FLAG1, 32'h0, 2'b11);
    @(posedge clk_in);
    go <= 1'b1; gk <= 2'h0; gb <= 16'h0004;
    repeat (2) @(posedge clk_in);
    wr(`IFEB_OFS_FLAG1, 32'h0, 2'b11);
    @(posedge clk_in);
    go <= 1'b0;
    repeat (2) @(posedge clk_in);
    ef[1] = 16'h0004;
    evst[0] = 1'b1;
    check_all();
    for (int i = 1; i <= 4; i++) fire(i, 16'hffff);
    check_all();
    for (int it = 0; it < 300; it++)
    begin
      @(posedge clk_in);
      flag0 <= 16'($urandom); en1 <= 16'($urandom); en2 <= 16'($urandom);
      en3 <= 16'($urandom); en4 <= 16'($urandom);
      case ($urandom_range(0, 2))
        0: fire($urandom_range(1, 4), 16'($urandom));
        1: wr(adr_tab[$urandom_range(0, 8)], $urandom, 2'($urandom_range(0, 3)));
        default: rd(adr_tab[$urandom_range(0, 8)]);
      endcase
      check_all();
    end
    test_done();
  end
endmodule // interrupt_flag_enable_bank_bench
